// ===== ssrw_regs.svh
// constants of the serial sram status and command block
// assumes inclusion by bare name from the design files
`ifndef SSRW_REGS_SVH
`define SSRW_REGS_SVH

`define SSRW_OP_STATUS_WRITE 8'h01
`define SSRW_OP_ARRAY_WRITE 8'h02
`define SSRW_OP_ARRAY_READ 8'h03
`define SSRW_OP_WRITE_LOCK 8'h04
`define SSRW_OP_STATUS_READ 8'h05
`define SSRW_OP_WRITE_UNLOCK 8'h06

`define SSRW_BIT_RSVD_HI 7
`define SSRW_BIT_AUTOSTORE_DIS 6
`define SSRW_BIT_RSVD_LO 5
`define SSRW_BIT_SECURE_FAIL 4
`define SSRW_BIT_PROT_HI 3
`define SSRW_BIT_PROT_LO 2
`define SSRW_BIT_WEL 1
`define SSRW_BIT_BUSY 0

`define SSRW_AUTOSTORE_DIS_RST 1'h0
`define SSRW_PROTECT_RST 2'h0
`define SSRW_WEL_RST 1'h0
`define SSRW_STATUS_RST 8'h00

`define SSRW_PROT_NONE 2'h0
`define SSRW_PROT_QUARTER 2'h1
`define SSRW_PROT_HALF 2'h2

`define SSRW_BIT_LAST 3'h7
`define SSRW_BIT_FIRST 3'h0

`endif

// ===== ssrw_pkg.sv
// types of the serial sram status and command block
// assumes nothing of its surroundings
package ssrw_pkg;

    typedef enum logic [2:0] {
        PH_OPCODE = 3'b000,
        PH_ADDR = 3'b001,
        PH_READ_DATA = 3'b010,
        PH_WRITE_DATA = 3'b011,
        PH_STATUS_DATA = 3'b100,
        PH_STATUS_OUT = 3'b101,
        PH_IGNORE = 3'b110
    } ssrw_phase_t;

    typedef enum logic [1:0] {
        EV_NONE = 2'b00,
        EV_WEL_SET = 2'b01,
        EV_WEL_CLEAR = 2'b10,
        EV_STATUS_WRITE = 2'b11
    } ssrw_event_t;

endpackage

// ===== ssrw_core.sv
// spi slave command logic of a serial sram: status byte, status commands, array read and write
// assumes an spi master on sck/csN/si/so (mode 0, msb first) and a store/recall engine on ref_clk
`timescale 1ns/10ps
`include "ssrw_regs.svh"

// Functional notes
// - status bit 6 set disables automatic backup; clear (reset) enables it.
// - status bit 4 is read-only, mirrors the last secure write failure.
// - status bits 3:2 select protection: none, upper quarter, upper half, all.
// - writes into the protected region are not stored.
// - status bit 1 shows the write-enable latch, never loaded from the status write byte.
// - write-enable latch gates status and array writes; only the unlock command sets it.
// - status bit 0 shows busy; while busy only status read executes.
// - opcode 05h returns the 8-bit status on serial output.
// - continued clocking reloads the status at every byte boundary.
// - status write touches only writable bits; new commands accepted right after.
// - status goes to nonvolatile copy only when a store runs.
// - opcode 03h plus address starts an array read, only when not busy.
// - read streams successive bytes, wrapping at array end, ignoring serial input.
// - chip select rising ends a read at once.
// - array write without the latch set is ignored until chip select rises.
// - array write is volatile only; no wait before the next command.
// - finishing an array write clears the write-enable latch.
// - continuous write stores at successive addresses, wrapping at array end.
// - a partial final byte is dropped; full bytes are still written.
// - 06h sets the latch, 04h clears it; no address or data.
// - status write is 01h plus one byte; array write is 02h.
// - every opcode, address and data byte is msb first.
// - a write aimed at a protected location clears the latch.
module ssrw_core #(
    parameter int ADDR_W = 16,
    parameter int ADDR_BYTES = 2
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic csN,
    input wire logic si,
    output logic so,
    output logic soOeN,
    input wire logic busyIn,
    input wire logic swfIn,
    input wire logic storeStart,
    output logic autostoreDisable,
    output logic [1:0] protectLevel,
    output logic writeEnabled,
    output logic [7:0] nvStatus
);

    localparam int DEPTH = 1 << ADDR_W;
    localparam int ASW = 8 * ADDR_BYTES;
    localparam logic [1:0] ADDR_LAST = 2'(ADDR_BYTES - 1);

    function automatic logic isProtected(input logic [1:0] lvl, input logic [ADDR_W-1:0] a);
        logic hit;
        hit = 1'b1;
        unique case (lvl)
            `SSRW_PROT_NONE: hit = 1'b0;
            `SSRW_PROT_QUARTER: hit = a[ADDR_W-1] & a[ADDR_W-2];
            `SSRW_PROT_HALF: hit = a[ADDR_W-1];
            default: hit = 1'b1;
        endcase
        return hit;
    endfunction

    // reference clock side
    logic rstMeta;
    logic rstSyncN;
    logic busyReg;
    logic swfReg;
    logic aseReg;
    logic [1:0] protReg;
    logic welReg;
    logic [7:0] nvStatusReg;
    logic [7:0] statusByte;
    logic evS1;
    logic evS2;
    logic evS3;
    logic evSeen;
    logic evFire;

    // link side
    logic [7:0] stS1;
    logic [7:0] stS2;
    logic [7:0] stS3;
    logic [7:0] stView;
    ssrw_pkg::ssrw_phase_t phase;
    logic [2:0] bitCnt;
    logic [6:0] rxShift;
    logic [7:0] rxByte;
    logic [1:0] addrCnt;
    logic [ASW-1:0] addrShift;
    logic [ASW-1:0] addrFull;
    logic [ADDR_W-1:0] addrReg;
    logic isRead;
    logic [7:0] txReg;
    logic evTog;
    ssrw_pkg::ssrw_event_t evCode;
    logic [7:0] evData;
    logic memWr;
    logic byteDone;
    logic viewBusy;
    logic viewWel;
    logic frameClr;
    logic [7:0] mem [0:DEPTH-1];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // status flags owned by the store/recall and secure-write engines
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            busyReg <= 1'b0;
            swfReg <= 1'b0;
        end else begin
            busyReg <= busyIn;
            swfReg <= swfIn;
        end
    end

    // toggle event from the link; code and data are stable well before the toggle settles
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            evS1 <= 1'b0;
            evS2 <= 1'b0;
            evS3 <= 1'b0;
            evSeen <= 1'b0;
        end else begin
            evS1 <= evTog;
            evS2 <= evS1;
            evS3 <= evS2;
            if (evS2 == evS3) begin
                evSeen <= evS3;
            end
        end
    end

    assign evFire = (evS2 == evS3) && (evS3 != evSeen);

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            aseReg <= `SSRW_AUTOSTORE_DIS_RST;
            protReg <= `SSRW_PROTECT_RST;
        end else if (evFire && evCode == ssrw_pkg::EV_STATUS_WRITE) begin
            aseReg <= evData[`SSRW_BIT_AUTOSTORE_DIS];
            protReg <= evData[`SSRW_BIT_PROT_HI:`SSRW_BIT_PROT_LO];
        end
    end

    // latch moves only on link events; completing a status write clears it
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            welReg <= `SSRW_WEL_RST;
        end else if (evFire) begin
            unique case (evCode)
                ssrw_pkg::EV_WEL_SET: welReg <= 1'b1;
                ssrw_pkg::EV_WEL_CLEAR: welReg <= 1'b0;
                ssrw_pkg::EV_STATUS_WRITE: welReg <= 1'b0;
                ssrw_pkg::EV_NONE: welReg <= welReg;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            nvStatusReg <= `SSRW_STATUS_RST;
        end else if (storeStart) begin
            nvStatusReg <= statusByte;
        end
    end

    always_comb begin
        statusByte = `SSRW_STATUS_RST;
        statusByte[`SSRW_BIT_AUTOSTORE_DIS] = aseReg;
        statusByte[`SSRW_BIT_SECURE_FAIL] = swfReg;
        statusByte[`SSRW_BIT_PROT_HI:`SSRW_BIT_PROT_LO] = protReg;
        statusByte[`SSRW_BIT_WEL] = welReg;
        statusByte[`SSRW_BIT_BUSY] = busyReg;
    end

    assign autostoreDisable = aseReg;
    assign protectLevel = protReg;
    assign writeEnabled = welReg;
    assign nvStatus = nvStatusReg;

    // status view in the link domain; a bit moves only once stages two and three agree
    always_ff @(posedge sck or negedge rstSyncN) begin
        if (!rstSyncN) begin
            stS1 <= `SSRW_STATUS_RST;
            stS2 <= `SSRW_STATUS_RST;
            stS3 <= `SSRW_STATUS_RST;
            stView <= `SSRW_STATUS_RST;
        end else begin
            stS1 <= statusByte;
            stS2 <= stS1;
            stS3 <= stS2;
            stView <= (stS2 & stS3) | (stView & (stS2 | stS3));
        end
    end

    assign viewBusy = stView[`SSRW_BIT_BUSY];
    assign viewWel = stView[`SSRW_BIT_WEL];
    assign rxByte = {rxShift, si};
    assign byteDone = (bitCnt == `SSRW_BIT_LAST);
    assign addrFull = ASW'({addrShift[ASW-9:0], rxByte});
    // internal reset clears frame state too: chip select may never toggle before the first frame
    assign frameClr = csN || !rstSyncN;

    // frame state: chip select high clears it at once, so an aborted frame leaves nothing behind
    always_ff @(posedge sck or posedge frameClr) begin
        if (frameClr) begin
            phase <= ssrw_pkg::PH_OPCODE;
            bitCnt <= `SSRW_BIT_FIRST;
            rxShift <= 7'h00;
            addrCnt <= 2'h0;
            addrShift <= '0;
            addrReg <= '0;
            isRead <= 1'b0;
        end else begin
            bitCnt <= 3'(bitCnt + 3'h1);
            rxShift <= rxByte[6:0];
            if (byteDone) begin
                unique case (phase)
                    ssrw_pkg::PH_OPCODE: begin
                        if (viewBusy && rxByte != `SSRW_OP_STATUS_READ) begin
                            phase <= ssrw_pkg::PH_IGNORE;
                        end else begin
                            unique case (rxByte)
                                `SSRW_OP_STATUS_READ: phase <= ssrw_pkg::PH_STATUS_OUT;
                                `SSRW_OP_STATUS_WRITE: begin
                                    phase <= viewWel ? ssrw_pkg::PH_STATUS_DATA : ssrw_pkg::PH_IGNORE;
                                end
                                `SSRW_OP_ARRAY_READ: begin
                                    phase <= ssrw_pkg::PH_ADDR;
                                    isRead <= 1'b1;
                                end
                                `SSRW_OP_ARRAY_WRITE: begin
                                    phase <= viewWel ? ssrw_pkg::PH_ADDR : ssrw_pkg::PH_IGNORE;
                                    isRead <= 1'b0;
                                end
                                default: phase <= ssrw_pkg::PH_IGNORE;
                            endcase
                        end
                    end
                    ssrw_pkg::PH_ADDR: begin
                        addrShift <= addrFull;
                        addrCnt <= 2'(addrCnt + 2'h1);
                        if (addrCnt == ADDR_LAST) begin
                            addrReg <= addrFull[ADDR_W-1:0];
                            phase <= isRead ? ssrw_pkg::PH_READ_DATA : ssrw_pkg::PH_WRITE_DATA;
                        end
                    end
                    ssrw_pkg::PH_READ_DATA: addrReg <= ADDR_W'(addrReg + 1'b1);
                    ssrw_pkg::PH_WRITE_DATA: addrReg <= ADDR_W'(addrReg + 1'b1);
                    ssrw_pkg::PH_STATUS_DATA: phase <= ssrw_pkg::PH_IGNORE;
                    ssrw_pkg::PH_STATUS_OUT: phase <= ssrw_pkg::PH_STATUS_OUT;
                    ssrw_pkg::PH_IGNORE: phase <= ssrw_pkg::PH_IGNORE;
                    default: phase <= ssrw_pkg::PH_IGNORE;
                endcase
            end
        end
    end

    // events toward the reference side; spacing of eight sck edges covers the three-stage sync
    always_ff @(posedge sck or negedge rstSyncN) begin
        if (!rstSyncN) begin
            evTog <= 1'b0;
            evCode <= ssrw_pkg::EV_NONE;
            evData <= `SSRW_STATUS_RST;
        end else if (!csN && byteDone) begin
            if (phase == ssrw_pkg::PH_OPCODE && !viewBusy && rxByte == `SSRW_OP_WRITE_UNLOCK) begin
                evCode <= ssrw_pkg::EV_WEL_SET;
                evTog <= ~evTog;
            end else if (phase == ssrw_pkg::PH_OPCODE && !viewBusy && rxByte == `SSRW_OP_WRITE_LOCK) begin
                evCode <= ssrw_pkg::EV_WEL_CLEAR;
                evTog <= ~evTog;
            end else if (phase == ssrw_pkg::PH_STATUS_DATA) begin
                evCode <= ssrw_pkg::EV_STATUS_WRITE;
                evData <= rxByte;
                evTog <= ~evTog;
            end else if (phase == ssrw_pkg::PH_WRITE_DATA) begin
                evCode <= ssrw_pkg::EV_WEL_CLEAR;
                evTog <= ~evTog;
            end
        end
    end

    // array is volatile; nothing here starts a store
    assign memWr = !csN && byteDone && phase == ssrw_pkg::PH_WRITE_DATA &&
                   !isProtected(stView[`SSRW_BIT_PROT_HI:`SSRW_BIT_PROT_LO], addrReg);

    always_ff @(posedge sck) begin
        if (memWr) begin
            mem[addrReg] <= rxByte;
        end
    end

    // output shifts on the falling edge so the master samples a settled bit on the rising edge
    always_ff @(negedge sck or posedge frameClr) begin
        if (frameClr) begin
            txReg <= 8'h00;
        end else if (bitCnt == `SSRW_BIT_FIRST && phase == ssrw_pkg::PH_READ_DATA) begin
            txReg <= mem[addrReg];
        end else if (bitCnt == `SSRW_BIT_FIRST && phase == ssrw_pkg::PH_STATUS_OUT) begin
            txReg <= stView;
        end else begin
            txReg <= {txReg[6:0], 1'b0};
        end
    end

    assign so = txReg[7];
    assign soOeN = csN || !(phase == ssrw_pkg::PH_READ_DATA || phase == ssrw_pkg::PH_STATUS_OUT);

    sequence srWriteSeen;
        evFire && evCode == ssrw_pkg::EV_STATUS_WRITE;
    endsequence

    sequence unlockSeen;
        evFire && evCode == ssrw_pkg::EV_WEL_SET;
    endsequence

    sequence opcodeDone;
        !csN && byteDone && phase == ssrw_pkg::PH_OPCODE;
    endsequence

    wel_set_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN) unlockSeen |=> welReg)
        else $error("latch not set after unlock");

    wel_clear_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        evFire && evCode == ssrw_pkg::EV_WEL_CLEAR |=> !welReg)
        else $error("latch not cleared");

    status_write_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        srWriteSeen |=> aseReg == $past(evData[`SSRW_BIT_AUTOSTORE_DIS]) && !welReg &&
        protReg == $past(evData[`SSRW_BIT_PROT_HI:`SSRW_BIT_PROT_LO]))
        else $error("status write did not land");

    wel_only_events_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        !evFire |=> $stable(welReg))
        else $error("latch moved without a command");

    busy_mirror_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        statusByte[`SSRW_BIT_BUSY] == $past(busyIn) && statusByte[`SSRW_BIT_SECURE_FAIL] == $past(swfIn))
        else $error("busy or fail flag not mirrored");

    nv_hold_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        !storeStart |=> $stable(nvStatusReg))
        else $error("nonvolatile copy changed without store");

    busy_ignore_a: assert property (@(posedge sck) disable iff (csN)
        opcodeDone and (viewBusy && rxByte != `SSRW_OP_STATUS_READ) |=> phase == ssrw_pkg::PH_IGNORE)
        else $error("command executed while busy");

    write_locked_a: assert property (@(posedge sck) disable iff (csN)
        opcodeDone and (!viewBusy && !viewWel && rxByte == `SSRW_OP_ARRAY_WRITE) |=> phase == ssrw_pkg::PH_IGNORE)
        else $error("array write taken without latch");

    // written out apart from the helper function so a slip in either one shows up
    protect_write_a: assert property (@(posedge sck) disable iff (csN)
        memWr |-> !(stView[`SSRW_BIT_PROT_HI] && stView[`SSRW_BIT_PROT_LO]) &&
        !(stView[`SSRW_BIT_PROT_HI] && addrReg[ADDR_W-1]) &&
        !(stView[`SSRW_BIT_PROT_LO] && addrReg[ADDR_W-1] && addrReg[ADDR_W-2]))
        else $error("protected location written");

    so_shift_a: assert property (@(negedge sck) disable iff (csN)
        phase == ssrw_pkg::PH_STATUS_OUT && bitCnt != `SSRW_BIT_FIRST && $past(bitCnt) != `SSRW_BIT_FIRST |->
        so == $past(txReg[6]))
        else $error("output not msb first");

endmodule

// ===== ssrw_spi_master.sv
// behavioural spi master (mode 0, msb first) facing the serial sram status block
// assumes one caller of frame() at a time; sck stands low outside frames
`timescale 1ns/10ps
module ssrw_spi_master #(
    parameter realtime HALF = 15.0
) (
    output logic sck,
    output logic csN,
    output logic si,
    input wire logic so,
    input wire logic soOeN
);
    logic [63:0] rxv;

    initial begin
        sck = 1'b0;
        csN = 1'b1;
        si = 1'b0;
        rxv = 'x;
    end

    // clocks nbits of tx out from bit 63 down; so is sampled on each rising edge
    // an undriven so is recorded as x so that a silent device never passes for data
    task automatic frame(input logic [63:0] tx, input int nbits);
        int i;
        rxv = 'x;
        csN = 1'b0;
        #(HALF);
        for (i = 0; i < nbits; i++) begin
            si = tx[63 - i];
            #(HALF);
            sck = 1'b1;
            rxv[63 - i] = (soOeN === 1'b0) ? so : 1'bx;
            #(HALF);
            sck = 1'b0;
        end
        #(HALF);
        csN = 1'b1;
        si = ~si;
        // gap lets a latch change reach the reference side before the next opcode
        #250;
    endtask
endmodule

// ===== spi_sram_status_rw_logic_tb.sv
// self-checking bench for the serial sram status and command block
// assumes ssrw_spi_master as the far side; ref_clk 20 ns, sck 30 ns only inside frames
`timescale 1ns/10ps
`include "ssrw_regs.svh"
module spi_sram_status_rw_logic_tb;
    logic ref_clk, rst_n, sck, csN, si, so, soOeN, busyIn, swfIn, storeStart;
    logic autostoreDisable, writeEnabled;
    logic [1:0] protectLevel;
    logic [7:0] nvStatus, rd;
    logic expAse, expSwf, expBusy;
    logic [1:0] expProt;
    int err_count = 0;
    int checks_done = 0;

    ssrw_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .csN(csN), .si(si), .so(so),
        .soOeN(soOeN), .busyIn(busyIn), .swfIn(swfIn), .storeStart(storeStart),
        .autostoreDisable(autostoreDisable), .protectLevel(protectLevel),
        .writeEnabled(writeEnabled), .nvStatus(nvStatus));
    ssrw_spi_master master (.sck(sck), .csN(csN), .si(si), .so(so), .soOeN(soOeN));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic [7:0] stat(input logic write_enable_latch);
        return {1'b0, expAse, 1'b0, expSwf, expProt, write_enable_latch, expBusy};
    endfunction

    task automatic chk(input string what, input logic [7:0] expv, input logic [7:0] got);
        checks_done++;
        if (got !== expv) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, expv, got);
        end
    endtask

    task automatic op(input logic [7:0] code);
        master.frame({code, 56'h0}, 8);
    endtask

    task automatic setStatus(input logic [7:0] v);
        op(`SSRW_OP_WRITE_UNLOCK);
        master.frame({`SSRW_OP_STATUS_WRITE, v, 48'h0}, 16);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        op(`SSRW_OP_WRITE_UNLOCK);
        master.frame({`SSRW_OP_ARRAY_WRITE, a, d, 32'h0}, 32);
    endtask

    task automatic rdByte(input logic [15:0] a);
        master.frame({`SSRW_OP_ARRAY_READ, a, 40'hFFFFFFFFFF}, 32);
        rd = master.rxv[39:32];
    endtask

    task automatic t_reset();
        chk("nvStatus", 8'h00, nvStatus);
        chk("outputs", 8'h00, {4'h0, autostoreDisable, protectLevel, writeEnabled});
        master.frame({`SSRW_OP_STATUS_READ, 56'h0}, 32);
        chk("status byte0", stat(1'b0), master.rxv[55:48]);
        chk("status byte1", stat(1'b0), master.rxv[47:40]);
        chk("status byte2", stat(1'b0), master.rxv[39:32]);
    endtask

    task automatic t_latch();
        op(`SSRW_OP_WRITE_UNLOCK);
        chk("latch set", 8'h01, {7'h0, writeEnabled});
        master.frame({`SSRW_OP_STATUS_READ, 56'h0}, 16);
        chk("status wel", stat(1'b1), master.rxv[55:48]);
        op(`SSRW_OP_WRITE_LOCK);
        chk("latch clear", 8'h00, {7'h0, writeEnabled});
        master.frame({`SSRW_OP_STATUS_WRITE, 8'h4C, 48'h0}, 16);
        chk("locked status write", 8'h00, {6'h0, protectLevel});
    endtask

    task automatic t_status_write();
        @(negedge ref_clk);
        swfIn = 1'b1;
        expSwf = 1'b1;
        // read-only bits sent as ones must not land
        setStatus(8'h53);
        expAse = 1'b1;
        master.frame({`SSRW_OP_STATUS_READ, 56'h0}, 16);
        chk("status after write", stat(1'b0), master.rxv[55:48]);
        chk("autostore disable", 8'h01, {7'h0, autostoreDisable});
        chk("nv before store", 8'h00, nvStatus);
        @(negedge ref_clk);
        storeStart = 1'b1;
        @(negedge ref_clk);
        storeStart = 1'b0;
        @(negedge ref_clk);
        chk("nv after store", stat(1'b0), nvStatus);
        swfIn = 1'b0;
        expSwf = 1'b0;
    endtask

    task automatic t_array();
        wr(16'h1234, 8'hA5);
        chk("latch after write", 8'h00, {7'h0, writeEnabled});
        // latch is clear now, so this write must leave the byte alone
        master.frame({`SSRW_OP_ARRAY_WRITE, 16'h1234, 8'h5A, 32'h0}, 32);
        rdByte(16'h1234);
        chk("byte read", 8'hA5, rd);
        wr(16'h0002, 8'h5A);
        op(`SSRW_OP_WRITE_UNLOCK);
        // wraps past the array end, then ends four bits into a byte
        master.frame({`SSRW_OP_ARRAY_WRITE, 16'hFFFF, 24'h112233, 8'hF0, 8'h0}, 52);
        master.frame({`SSRW_OP_ARRAY_READ, 16'hFFFF, 40'hFFFFFFFFFF}, 56);
        chk("wrap rd0", 8'h11, master.rxv[39:32]);
        chk("wrap rd1", 8'h22, master.rxv[31:24]);
        chk("wrap rd2", 8'h33, master.rxv[23:16]);
        chk("partial byte", 8'h5A, master.rxv[15:8]);
    endtask

    task automatic t_protect();
        logic [15:0] hi [0:2];
        logic [15:0] lo [0:1];
        int i;
        hi = '{16'hC000, 16'h8000, 16'h0000};
        lo = '{16'hBFFF, 16'h7FFF};
        for (i = 0; i < 3; i++) begin
            wr(hi[i], 8'h3C);
        end
        for (i = 0; i < 3; i++) begin
            expProt = 2'(i + 1);
            setStatus({4'h4, expProt, 2'b00});
            chk("protect level", {6'h0, expProt}, {6'h0, protectLevel});
            if (i < 2) begin
                wr(lo[i], 8'(i));
                rdByte(lo[i]);
                chk("unprotected write", 8'(i), rd);
            end
            wr(hi[i], 8'hC3);
            chk("latch after refusal", 8'h00, {7'h0, writeEnabled});
            rdByte(hi[i]);
            chk("protected byte", 8'h3C, rd);
        end
        expProt = 2'b00;
        setStatus(8'h40);
    endtask

    task automatic t_busy();
        @(negedge ref_clk);
        busyIn = 1'b1;
        expBusy = 1'b1;
        #200;
        master.frame({`SSRW_OP_STATUS_READ, 56'h0}, 16);
        chk("busy status", stat(1'b0), master.rxv[55:48]);
        // two bytes, so the refused opcode is still seen inside its own frame
        master.frame({`SSRW_OP_WRITE_UNLOCK, 56'h0}, 16);
        chk("unlock while busy", 8'h00, {7'h0, writeEnabled});
        rdByte(16'h1234);
        chk("read while busy", 8'hxx, rd);
        @(negedge ref_clk);
        busyIn = 1'b0;
        expBusy = 1'b0;
        #200;
        rdByte(16'h1234);
        chk("read after busy", 8'hA5, rd);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // about fifty frames of at most 2 us each; four times that is ample
    initial begin
        #400000;
        err_count++;
        test_done();
    end

    initial begin
        rst_n = 1'b0;
        busyIn = 1'b0;
        swfIn = 1'b0;
        storeStart = 1'b0;
        expAse = 1'b0;
        expSwf = 1'b0;
        expBusy = 1'b0;
        expProt = 2'b00;
        rd = 8'h00;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge ref_clk);
        t_reset();
        t_latch();
        t_status_write();
        t_array();
        t_protect();
        t_busy();
        test_done();
    end
endmodule
